// File: hw/iim_pkg.sv
package iim_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT1 = 8'h04;
  localparam logic [7:0] ADDR_STAT2 = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_OWN1 = 8'h10;
  localparam logic [7:0] ADDR_OWN2 = 8'h14;
  // Control register fields
  localparam int CTRL_PE = 0;
  localparam int CTRL_ENGC = 1;
  localparam int CTRL_START = 2;
  localparam int CTRL_ACK = 3;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_IRQ_EN = 5;
  // Status 1 fields
  localparam int ST_START_SENT = 0;
  localparam int ST_MSL = 1;
  localparam int ST_ADDR_MATCH = 2;
  localparam int ST_BTF = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_TRA = 5;
  localparam int ST_EVENT = 7;
  // Status 2 fields
  localparam int ST2_GCAL = 0;
  localparam int ST2_STOPF = 1;
  localparam int ST2_ARLO = 2;
  localparam int ST2_BERR = 3;
  localparam int ST2_AF = 4;
  // Own address 2 fields
  localparam int OA2_FAST = 7;
  localparam int OA2_ADD10 = 6;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OWN2_RST = 8'h00;
  // Divider: half period of SCL = base + 8*divider field in standard mode, base + divider field in fast mode; fast base a quarter of standard
  localparam int CLK_MHZ = 250;
  localparam int STD_KHZ = 100;
  localparam int FAST_KHZ = 400;
  localparam logic [11:0] STD_HALF = 12'((CLK_MHZ * 1000 + 2 * STD_KHZ - 1) / (2 * STD_KHZ));
  localparam logic [11:0] FAST_HALF = 12'((CLK_MHZ * 1000 + 2 * FAST_KHZ - 1) / (2 * FAST_KHZ));
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [4:0] HDR10 = 5'h1E;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_GSTART = 4'h1, ST_WAIT = 4'h2, ST_BIT = 4'h3,
    ST_ACKB = 4'h4, ST_GSTOP = 4'h5, ST_IGN = 4'h6
  } iim_state_t;
endpackage

// File: hw/iim_sync.sv
`timescale 1ns/1ps
// Three-stage input synchroniser with agreement filter
module iim_sync
  import iim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic s1_q, s2_q, s3_q;
  // Stage chain; first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Output changes once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dout <= 1'b1;
    else if (s2_q == s3_q)
      dout <= s3_q;
  end
endmodule

// File: hw/iim_clkdiv.sv
`timescale 1ns/1ps
// SCL half-period tick generator
module iim_clkdiv
  import iim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic fast,
  input wire logic [5:0] div_bits,
  output logic tick
);
  logic [11:0] cnt_q;
  logic [11:0] limit;
  // Divider limit depends on speed mode
  assign limit = fast ? (FAST_HALF + 12'(div_bits)) : (STD_HALF + {3'h0, div_bits, 3'h0});
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      cnt_q <= 12'h000;
      tick <= 1'b0;
    end
    else if (cnt_q >= limit - 12'h001)
    begin
      cnt_q <= 12'h000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 12'h001;
      tick <= 1'b0;
    end
  end
endmodule

// File: hw/iim_top.sv
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module iim_top
  import iim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  output logic event_irq
);
  logic [7:0] ctrl_q, own1_q, own2_q, dtx_q, drx_q, sh_q;
  logic aw_q, w_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic start_sent_q, msl_q, addr_match_q, btf_q, busy_q, tra_q, gcal_q, stopf_q, arlo_q, berr_q, af_q;
  logic dwr_q, drd_q, sr1_rd_q;
  logic sda_s, scl_s, sda_p_q, scl_p_q;
  logic start_det, stop_det, tick;
  logic scl_drv_q, sda_drv_q;
  logic [3:0] bit_q;
  logic addr_ph_q, phase_q;
  iim_state_t st_q;
  logic wr_go, rd_go, pe;
  logic [7:0] rd_byte;

  // Decode a register byte address into a read value
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] s1, input logic [7:0] s2);
    case (a)
      ADDR_CTRL: reg_read = ctrl_q;
      ADDR_STAT1: reg_read = s1;
      ADDR_STAT2: reg_read = s2;
      ADDR_DATA: reg_read = drx_q;
      ADDR_OWN1: reg_read = own1_q;
      ADDR_OWN2: reg_read = own2_q;
      default: reg_read = 8'h00;
    endcase
  endfunction

  assign pe = ctrl_q[CTRL_PE];
  logic [7:0] stat1, stat2;
  logic event_flag;
  assign stat2 = {3'h0, af_q, berr_q, arlo_q, stopf_q, gcal_q};
  assign event_flag = start_sent_q | addr_match_q | btf_q | (|stat2[4:1]);
  assign stat1 = {event_flag, 1'b0, tra_q, busy_q, btf_q, addr_match_q, msl_q, start_sent_q};
  assign event_irq = event_flag & ctrl_q[CTRL_IRQ_EN];

  // Line synchronisers and condition detection
  iim_sync u_sda (.aclk(aclk), .aresetn(aresetn), .din(serial_data_pin_i), .dout(sda_s));
  iim_sync u_scl (.aclk(aclk), .aresetn(aresetn), .din(serial_clock_pin_i), .dout(scl_s));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
    end
    else
    begin
      sda_p_q <= sda_s;
      scl_p_q <= scl_s;
    end
  end
  assign start_det = pe & scl_s & scl_p_q & sda_p_q & !sda_s;
  assign stop_det = pe & scl_s & scl_p_q & !sda_p_q & sda_s;

  iim_clkdiv u_div (.aclk(aclk), .aresetn(aresetn), .run(msl_q), .fast(own2_q[OA2_FAST]),
    .div_bits(own2_q[5:0]), .tick(tick));

  // AXI4-Lite handshakes, one write and one read at a time
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_byte = reg_read(s_axi_araddr, stat1, stat2);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awa_q <= ADDR_OWN2 && awa_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= (s_axi_araddr <= ADDR_OWN2 && s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Software registers; start/stop bits self-clear when acted on
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RST;
      own1_q <= 8'h00;
      own2_q <= OWN2_RST;
      dtx_q <= 8'h00;
      dwr_q <= 1'b0;
    end
    else
    begin
      if (wr_go && wd_q[0] && s_axi_wstrb[0])
      begin
        if (awa_q == ADDR_CTRL)
          ctrl_q <= wd_q[7:0];
        if (awa_q == ADDR_OWN1)
          own1_q <= wd_q[7:0];
        if (awa_q == ADDR_OWN2)
          own2_q <= wd_q[7:0];
      end
      else if (wr_go && s_axi_wstrb[0])
      begin
        if (awa_q == ADDR_CTRL)
          ctrl_q <= wd_q[7:0];
        if (awa_q == ADDR_OWN1)
          own1_q <= wd_q[7:0];
        if (awa_q == ADDR_OWN2)
          own2_q <= wd_q[7:0];
      end
      if (st_q == ST_GSTART && phase_q && tick)
        ctrl_q[CTRL_START] <= 1'b0;
      if (st_q == ST_GSTOP && phase_q && tick)
        ctrl_q[CTRL_STOP] <= 1'b0;
      if (wr_go && s_axi_wstrb[0] && awa_q == ADDR_DATA)
      begin
        dtx_q <= wd_q[7:0];
        dwr_q <= 1'b1;
      end
      else if (st_q == ST_WAIT && tra_q && dwr_q)
        dwr_q <= 1'b0;
    end
  end

  // Protocol engine: master sequencing, slave addressing, byte shift
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !pe)
    begin
      st_q <= ST_IDLE;
      msl_q <= 1'b0;
      start_sent_q <= 1'b0;
      addr_match_q <= 1'b0;
      btf_q <= 1'b0;
      busy_q <= 1'b0;
      tra_q <= 1'b0;
      gcal_q <= 1'b0;
      stopf_q <= 1'b0;
      arlo_q <= 1'b0;
      berr_q <= 1'b0;
      af_q <= 1'b0;
      sh_q <= 8'h00;
      drx_q <= 8'h00;
      bit_q <= 4'h0;
      phase_q <= 1'b0;
      addr_ph_q <= 1'b0;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
      drd_q <= 1'b0;
      sr1_rd_q <= 1'b0;
    end
    else
    begin
      // Status 2 reads clear its event flags; status 1 reads only arm the next data step; new events win over the clear
      if (rd_go && s_axi_araddr == ADDR_STAT1)
        sr1_rd_q <= 1'b1;
      if (rd_go && s_axi_araddr == ADDR_STAT2)
      begin
        stopf_q <= 1'b0;
        arlo_q <= 1'b0;
        berr_q <= 1'b0;
        af_q <= 1'b0;
        gcal_q <= 1'b0;
      end
      if (rd_go && s_axi_araddr == ADDR_DATA)
        drd_q <= 1'b1;
      if (start_det)
        busy_q <= 1'b1;
      if (stop_det)
        busy_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          scl_drv_q <= 1'b0;
          sda_drv_q <= 1'b0;
          if (ctrl_q[CTRL_START] && !busy_q)
          begin
            st_q <= ST_GSTART;
            msl_q <= 1'b1;
            phase_q <= 1'b0;
          end
          else if (start_det)
          begin
            st_q <= ST_BIT;
            tra_q <= 1'b0;
            addr_ph_q <= 1'b1;
            bit_q <= 4'h0;
          end
        end
        ST_GSTART:
        begin
          if (tick)
          begin
            phase_q <= !phase_q;
            if (!phase_q)
              sda_drv_q <= 1'b1;
            else
            begin
              scl_drv_q <= 1'b1;
              start_sent_q <= 1'b1;
              st_q <= ST_WAIT;
              tra_q <= 1'b1;
              addr_ph_q <= 1'b1;
              sr1_rd_q <= 1'b0;
            end
          end
        end
        ST_WAIT:
        begin
          scl_drv_q <= 1'b1;
          if (msl_q && ctrl_q[CTRL_STOP])
          begin
            st_q <= ST_GSTOP;
            phase_q <= 1'b0;
            sda_drv_q <= 1'b1;
          end
          else if (tra_q && dwr_q && sr1_rd_q)
          begin
            sh_q <= dtx_q;
            start_sent_q <= 1'b0;
            btf_q <= 1'b0;
            addr_match_q <= 1'b0;
            bit_q <= 4'h0;
            phase_q <= 1'b0;
            st_q <= ST_BIT;
          end
          else if (!tra_q && drd_q)
          begin
            btf_q <= 1'b0;
            addr_match_q <= 1'b0;
            bit_q <= 4'h0;
            phase_q <= 1'b0;
            st_q <= ST_BIT;
            scl_drv_q <= 1'b0;
          end
        end
        ST_BIT:
        begin
          if (msl_q)
          begin
            // Master: low phase sets data, high phase samples and checks arbitration
            // Data moves only while SCL is held low, never with an SCL edge
            if (!tick && !phase_q && scl_drv_q)
            begin
              if (bit_q < 4'h8)
                sda_drv_q <= tra_q ? !sh_q[7] : 1'b0;
              else
                sda_drv_q <= !tra_q && ctrl_q[CTRL_ACK];
            end
            if (tick)
            begin
              phase_q <= !phase_q;
              scl_drv_q <= phase_q;
              if (phase_q && bit_q < 4'h8)
              begin
                if (tra_q && sh_q[7] && !sda_s)
                begin
                  arlo_q <= 1'b1;
                  msl_q <= 1'b0;
                  sda_drv_q <= 1'b0;
                  scl_drv_q <= 1'b0;
                  st_q <= ST_IGN;
                end
                sh_q <= {sh_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
              end
              else if (phase_q)
              begin
                if (tra_q && sda_s)
                  af_q <= 1'b1;
                if (!tra_q)
                  drx_q <= sh_q;
                btf_q <= 1'b1;
                drd_q <= 1'b0;
                sr1_rd_q <= 1'b0;
                if (addr_ph_q && !sh_q[0] && dtx_q[7:3] != HDR10)
                  addr_ph_q <= 1'b0;
                else if (addr_ph_q && sh_q[0])
                begin
                  addr_ph_q <= 1'b0;
                  tra_q <= 1'b0;
                end
                st_q <= ST_WAIT;
              end
            end
          end
          else
          begin
            // Slave: sample on SCL rise, drive on SCL fall
            if (start_det)
            begin
              bit_q <= 4'h0;
              addr_ph_q <= 1'b1;
              sda_drv_q <= 1'b0;
            end
            else if (stop_det)
            begin
              stopf_q <= 1'b1;
              sda_drv_q <= 1'b0;
              st_q <= ST_IDLE;
            end
            else if (scl_s && !scl_p_q && bit_q < 4'h8)
            begin
              sh_q <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end
            else if (!scl_s && scl_p_q)
            begin
              if (bit_q == 4'h8 && addr_ph_q)
              begin
                if ((sh_q[7:1] == own1_q[7:1] && !own2_q[OA2_ADD10]) ||
                    (sh_q[7:1] == {HDR10, own2_q[5:4]} && own2_q[OA2_ADD10]))
                begin
                  sda_drv_q <= ctrl_q[CTRL_ACK];
                  addr_match_q <= 1'b1;
                  tra_q <= sh_q[0];
                  addr_ph_q <= 1'b0;
                  bit_q <= 4'h9;
                end
                else if (sh_q == GCALL_ADDR && ctrl_q[CTRL_ENGC])
                begin
                  sda_drv_q <= ctrl_q[CTRL_ACK];
                  addr_match_q <= 1'b1;
                  gcal_q <= 1'b1;
                  addr_ph_q <= 1'b0;
                  bit_q <= 4'h9;
                end
                else
                  st_q <= ST_IGN;
              end
              else if (bit_q == 4'h8)
              begin
                sda_drv_q <= ctrl_q[CTRL_ACK];
                drx_q <= sh_q;
                btf_q <= 1'b1;
                bit_q <= 4'h9;
              end
              else if (bit_q == 4'h9)
              begin
                sda_drv_q <= 1'b0;
                drd_q <= 1'b0;
                sr1_rd_q <= 1'b0;
                st_q <= ST_WAIT;
              end
            end
          end
        end
        ST_GSTOP:
        begin
          if (tick)
          begin
            phase_q <= !phase_q;
            if (!phase_q)
              scl_drv_q <= 1'b0;
            else
            begin
              sda_drv_q <= 1'b0;
              msl_q <= 1'b0;
              tra_q <= 1'b0;
              st_q <= ST_IDLE;
            end
          end
        end
        ST_IGN:
        begin
          sda_drv_q <= 1'b0;
          scl_drv_q <= 1'b0;
          if (start_det)
          begin
            st_q <= ST_BIT;
            addr_ph_q <= 1'b1;
            bit_q <= 4'h0;
          end
          else if (stop_det)
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Open-drain pins: drive low only while enabled
  assign serial_data_pin_o = 1'b0;
  assign serial_clock_pin_o = 1'b0;
  assign serial_data_pin_oe = pe & sda_drv_q;
  assign serial_clock_pin_oe = pe & scl_drv_q;

  // Checks
  master_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == ST_IDLE || st_q == ST_IGN) |-> !msl_q) else $error("master flag outside transfer");
  disabled_pins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pe |-> !serial_data_pin_oe && !serial_clock_pin_oe) else $error("pins driven while disabled");
  start_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(start_sent_q) |-> msl_q && st_q == ST_WAIT) else $error("start flag outside master");
  ignore_lines_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_IGN ##1 st_q == ST_IGN |-> !serial_data_pin_oe) else $error("unmatched slave drives");
  gcall_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(gcal_q) |-> $past(ctrl_q[CTRL_ENGC])) else $error("general call while disabled");
  hold_scl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_WAIT ##1 st_q == ST_WAIT |-> serial_clock_pin_oe) else $error("clock not held");
  arb_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(arlo_q) |-> !msl_q) else $error("still master after arbitration loss");
  start_gen_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_IDLE ##1 st_q == ST_GSTART |-> $past(ctrl_q[CTRL_START])) else $error("unrequested start");
  start_cov: cover property (@(posedge aclk) $rose(start_sent_q));
  match_cov: cover property (@(posedge aclk) $rose(addr_match_q));
  stop_cov: cover property (@(posedge aclk) $rose(stopf_q));
endmodule

// File: tb/iim_slave_model.sv
`timescale 1ns/1ps
// Far-side bus slave: acks its own address and, once selected, every data byte
module iim_slave_model #(
  parameter logic [6:0] SLV_ADDR = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  output logic [7:0] last_byte,
  output int byte_count
);
  int bit_n = 0;
  logic sel = 1'b0;
  logic [7:0] shift_q = 8'h00;
  initial
  begin
    sda_oe = 1'b0;
    last_byte = 8'h00;
    byte_count = 0;
  end
  // Start or stop while the clock is high restarts the framing
  always @(sda)
  begin
    if (scl)
    begin
      bit_n = 0;
      if (!sda)
        byte_count = 0;
    end
  end
  // Data sampled on the rising clock, MSB first
  always @(posedge scl)
  begin
    if (bit_n < 8)
    begin
      shift_q = {shift_q[6:0], sda};
      bit_n++;
    end
  end
  // Ninth pulse carries our ack; line released after it
  always @(negedge scl)
  begin
    if (bit_n == 9)
    begin
      sda_oe = 1'b0;
      bit_n = 0;
    end
    else if (bit_n == 8)
    begin
      last_byte = shift_q;
      byte_count++;
      sda_oe = (byte_count == 1) ? (shift_q[7:1] == SLV_ADDR) : sel;
      if (byte_count == 1)
        sel = sda_oe;
      bit_n = 9;
    end
  end
endmodule

// File: tb/i2c_multimaster_interface_test.sv
`timescale 1ns/1ps
module i2c_multimaster_interface_test;
  import iim_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sda_oe, scl_oe, irq, mdl_oe;
  logic [1:0] bresp;
  logic [1:0] rsp;
  logic [31:0] rd;
  logic [7:0] mdl_byte;
  int mdl_count;
  int miscompares = 0;
  int comparisons = 0;
  // Open-drain lines with pull-ups
  wire sda = ~(sda_oe | mdl_oe);
  wire scl = ~scl_oe;
  always #2 aclk = ~aclk;
  iim_top iim_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rd),
    .s_axi_rresp(rsp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_data_pin_i(sda),
    .serial_data_pin_o(), .serial_data_pin_oe(sda_oe), .serial_clock_pin_i(scl),
    .serial_clock_pin_o(), .serial_clock_pin_oe(scl_oe), .event_irq(irq));
  iim_slave_model iim_slave_model_inst (.scl(scl), .sda(sda), .sda_oe(mdl_oe), .last_byte(mdl_byte),
    .byte_count(mdl_count));
  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic overrun(input int n, input string what);
    if (n > 5000)
    begin
      miscompares++;
      $display("[FAIL] %0t %s timed out", $time, what);
      stop_test();
    end
  endtask
  // Write; each channel released at the rising edge where it is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic tb;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      tb = bvalid;
      if (tb)
        bready <= 1'b0;
      n++;
      overrun(n * 100, "write");
    end
  endtask
  // Read; result left in rd and rsp as sampled with rvalid
  task automatic axi_rd(input logic [7:0] a);
    int n;
    logic tr;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      tr = rvalid;
      if (tr)
        rready <= 1'b0;
      n++;
      overrun(n * 100, "read");
    end
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    axi_rd(a);
    while (rd[b] !== v)
    begin
      axi_rd(a);
      n++;
      overrun(n, "poll");
    end
  endtask
  task automatic t_reset();
    axi_rd(ADDR_CTRL);
    check(rd, {24'h0, CTRL_RST}, "ctrl reset");
    axi_rd(ADDR_OWN2);
    check(rd, {24'h0, OWN2_RST}, "own2 reset");
    axi_rd(ADDR_STAT1);
    check(rd[ST_MSL], 1'b0, "slave after reset");
    check({sda_oe, scl_oe}, 2'h0, "pins idle");
    axi_rd(8'h20);
    check({rsp, rd}, {RESP_SLVERR, 32'h0}, "unmapped read");
    $display("t_reset done");
  endtask
  // Start, then send an address byte
  task automatic start_addr(input logic [7:0] a);
    axi_wr(ADDR_CTRL, 32'h29);
    axi_wr(ADDR_CTRL, 32'h2D);
    poll(ADDR_STAT1, ST_START_SENT, 1'b1);
    check({rd[ST_MSL], rd[ST_EVENT]}, 2'h3, "master with event");
    check(irq, 1'b1, "event interrupt");
    check(scl_oe, 1'b1, "clock held for address");
    axi_wr(ADDR_DATA, {24'h0, a});
  endtask
  task automatic t_master_tx();
    int n;
    axi_wr(ADDR_OWN2, 32'h83);
    start_addr(8'hA0);
    poll(ADDR_STAT1, ST_BTF, 1'b1);
    check(mdl_byte, 8'hA0, "address byte");
    axi_rd(ADDR_STAT2);
    check(rd[ST2_AF], 1'b0, "address acked");
    repeat (700) @(posedge aclk);
    check(scl_oe, 1'b1, "clock stretched");
    axi_wr(ADDR_DATA, 32'h5A);
    n = 0;
    while (scl_oe !== 1'b0)
    begin
      @(posedge aclk);
      n++;
      overrun(n, "clock");
    end
    while (scl_oe !== 1'b1)
    begin
      @(posedge aclk);
      n++;
      overrun(n, "clock");
    end
    n = 0;
    while (scl_oe === 1'b1)
    begin
      @(posedge aclk);
      n++;
      overrun(n, "clock");
    end
    check(n >= 316 && n <= 320, 1'b1, "fast half period");
    poll(ADDR_STAT1, ST_BTF, 1'b1);
    check({mdl_byte, 8'(mdl_count)}, 16'h5A02, "data byte");
    axi_wr(ADDR_CTRL, 32'h39);
    poll(ADDR_STAT1, ST_MSL, 1'b0);
    repeat (700) @(posedge aclk);
    check({sda_oe, scl_oe}, 2'h0, "lines free after stop");
    $display("t_master_tx done");
  endtask
  task automatic t_nack();
    start_addr(8'h66);
    poll(ADDR_STAT2, ST2_AF, 1'b1);
    check(mdl_count, 1, "one byte seen");
    axi_wr(ADDR_CTRL, 32'h39);
    poll(ADDR_STAT1, ST_MSL, 1'b0);
    $display("t_nack done");
  endtask
  task automatic t_disable();
    axi_wr(ADDR_CTRL, 32'h0);
    repeat (10) @(posedge aclk);
    check({sda_oe, scl_oe, irq}, 3'h0, "disabled pins");
    axi_rd(ADDR_STAT1);
    check(rd[ST_MSL], 1'b0, "slave when disabled");
    $display("t_disable done");
  endtask
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_master_tx();
    t_nack();
    t_disable();
    stop_test();
  end
endmodule
